//--- core/tol_top.sv
// Threshold object logic: two thresholds, delays, telegram triggers, register slave
`timescale 1ns/1ps
module tol_top
    import tol_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic                mclk,
    input  wire logic                reset_n,
    input  wire logic                clk_en,
    // Avalon-MM slave
    input  wire logic [5:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    // Measured value
    input  wire logic [15:0]         meas_value,
    input  wire logic                meas_valid,
    // Sensor supply pin
    input  wire logic                supply_ok,
    // Limit objects
    input  wire logic [NUM_THR-1:0]  ext16_valid,
    input  wire logic [31:0]         ext16_value,
    input  wire logic [NUM_THR-1:0]  ext8_valid,
    input  wire logic [15:0]         ext8_value,
    input  wire logic [NUM_THR-1:0]  teach_valid,
    input  wire logic [NUM_THR-1:0]  teach_value,
    // Threshold object telegrams
    output logic      [NUM_THR-1:0]  tx_valid,
    output logic      [NUM_THR-1:0]  threshold_level
);
    // ------
    // Reset release and pin synchroniser
    // ------
    logic       rst_meta;
    logic       rst_n;
    logic       sup_meta;
    logic       sup_sync;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sup_meta <= 1'b1;
            sup_sync <= 1'b1;
        end else if (clk_en) begin
            sup_meta <= supply_ok;
            sup_sync <= sup_meta;
        end
    end

    // ------
    // Seconds timebase
    // ------
    logic [31:0] pre_cnt;
    logic        tick;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt <= 32'h0;
            tick    <= 1'b0;
        end else if (clk_en) begin
            tick <= 1'b0;
            if (pre_cnt >= 32'(TICK_LEN - 1)) begin
                pre_cnt <= 32'h0;
                tick    <= 1'b1;
            end else begin
                pre_cnt <= pre_cnt + 32'd1;
            end
        end
    end

    // ------
    // Last measured value
    // ------
    logic [15:0] last_meas;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            last_meas <= 16'h0000;
        end else if (clk_en && meas_valid) begin
            last_meas <= meas_value;
        end
    end

    // ------
    // Bus slave
    // ------
    logic        ack;
    logic        wr_go;
    logic        reload;
    logic [31:0] cfg    [NUM_THR];
    logic [15:0] lim    [NUM_THR];
    logic [15:0] hyst   [NUM_THR];
    logic [31:0] status [NUM_THR];

    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_go           = clk_en && avs_write && ack;
    assign reload          = wr_go && avs_address == OFS_CTRL && avs_writedata[CTRL_RELOAD];

    function automatic int ch_of(input logic [5:0] a);
        int r;
        r = -1;
        for (int i = 0; i < NUM_THR; i++) begin
            if (a[5:4] == 2'(i + 1)) begin
                r = i;
            end
        end
        return r;
    endfunction : ch_of

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else if (clk_en) begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0;
        end else if (clk_en && avs_read && !ack) begin
            avs_readdata <= 32'h0;
            if (avs_address == OFS_MEAS) begin
                avs_readdata <= {16'h0000, last_meas};
            end
            for (int i = 0; i < NUM_THR; i++) begin
                if (ch_of(avs_address) == i) begin
                    case (avs_address[3:0])
                        OFS_CFG:    avs_readdata <= cfg[i];
                        OFS_LIMIT:  avs_readdata <= {16'h0000, lim[i]};
                        OFS_HYST:   avs_readdata <= {16'h0000, hyst[i]};
                        OFS_STATUS: avs_readdata <= status[i];
                        default:    avs_readdata <= 32'h0;
                    endcase
                end
            end
        end
    end

    // ------
    // Threshold channels
    // ------
    for (genvar g = 0; g < NUM_THR; g++) begin : g_thr // RL22
        logic [3:0]  md;
        logic        binary;
        logic        fault;
        logic        fault_q;
        logic [1:0]  fault_cnt;
        logic [15:0] act_lim;
        logic        active;
        logic        obj;
        logic        obj_q;
        logic        delayed;
        logic        delayed_q;
        logic        silent;
        logic [11:0] dly_s;
        logic        dly_load;
        logic        dly_stop;
        logic        dly_busy;
        logic        dly_exp;
        logic        cyc_fire;
        logic [16:0] lim_hi;
        logic [15:0] lim_lo;
        logic [7:0]  pct;
        tol_ext_t    ext;

        assign binary = cfg[g][CFG_BINARY];
        assign md     = binary ? 4'b0100 : tol_mode(cfg[g][CFG_MODE_LO +: 4]); // RL1
        assign ext    = tol_ext_t'(cfg[g][CFG_EXT_LO +: 2]);
        assign fault  = binary && cfg[g][CFG_SUP_MON] && !sup_sync;
        assign lim_hi = {1'b0, act_lim} + {1'b0, hyst[g]};
        assign lim_lo = (act_lim > hyst[g]) ? act_lim - hyst[g] : 16'h0000;
        assign pct    = (ext8_value[g*8 +: 8] > PCT_MAX) ? PCT_MAX : ext8_value[g*8 +: 8];
        assign obj    = md[2] ? active : !active;
        assign silent = (delayed == md[2]) ? md[1] : md[0]; // RL4 RL21
        assign status[g] = {12'h000, dly_busy, silent, delayed, obj, act_lim};

        // Configuration registers
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                cfg[g]  <= CFG_RESET;
                lim[g]  <= LIMIT_RESET;
                hyst[g] <= HYST_RESET;
            end else if (wr_go && ch_of(avs_address) == g) begin
                case (avs_address[3:0])
                    OFS_CFG:   cfg[g]  <= avs_writedata;
                    OFS_LIMIT: lim[g]  <= avs_writedata[15:0];
                    OFS_HYST:  hyst[g] <= avs_writedata[15:0];
                    default:   cfg[g]  <= cfg[g];
                endcase
            end
        end

        // Active limit source
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                act_lim <= LIMIT_RESET; // RL9
            end else if (clk_en) begin
                if (reload) begin
                    act_lim <= lim[g]; // RL9 RL8
                end else if (!binary) begin // RL6
                    if (ext == TOL_EXT_16 && ext16_valid[g]) begin
                        act_lim <= ext16_value[g*16 +: 16]; // RL5
                    end else if (ext == TOL_EXT_8 && ext8_valid[g]) begin
                        act_lim <= 16'(pct * PCT_SCALE); // RL5
                    end else if (ext == TOL_EXT_TEACH && teach_valid[g] && teach_value[g]) begin
                        act_lim <= last_meas; // RL7
                    end
                end
            end
        end

        // Comparison with hysteresis
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                active <= 1'b0;
            end else if (clk_en && meas_valid) begin // RL23
                if (binary) begin
                    active <= meas_value[0];
                end else if (!md[3]) begin
                    if (!active && meas_value > act_lim) begin
                        active <= 1'b1; // RL2
                    end else if (active && meas_value < lim_lo) begin
                        active <= 1'b0; // RL2
                    end
                end else begin
                    if (!active && meas_value < act_lim) begin
                        active <= 1'b1; // RL3
                    end else if (active && {1'b0, meas_value} > lim_hi) begin
                        active <= 1'b0; // RL3
                    end
                end
            end
        end

        // Delay selection and timer control
        assign dly_s    = obj ? tol_delay_s(cfg[g][CFG_ON_LO +: 3])
                              : tol_delay_s(cfg[g][CFG_OFF_LO +: 3]); // RL10 RL14
        assign dly_load = (obj != obj_q) && (obj != delayed) && dly_s != 12'd0 && !fault; // RL12
        assign dly_stop = (obj != obj_q) && (obj == delayed) || fault; // RL13

        tol_delay u_delay (
            .mclk   (mclk),
            .rst_n  (rst_n),
            .clk_en (clk_en),
            .tick   (tick),
            .load   (dly_load),
            .secs   (dly_s),
            .stop   (dly_stop),
            .busy   (dly_busy),
            .expire (dly_exp)
        );

        tol_cycle u_cycle (
            .mclk   (mclk),
            .rst_n  (rst_n),
            .clk_en (clk_en),
            .tick   (tick),
            .factor (cfg[g][CFG_CYC_LO +: 7]),
            .fire   (cyc_fire)
        );

        // Delayed state
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                obj_q     <= 1'b0;
                delayed   <= 1'b0;
                delayed_q <= 1'b0;
                fault_q   <= 1'b0;
            end else if (clk_en) begin
                obj_q     <= obj;
                delayed_q <= delayed;
                fault_q   <= fault;
                if (fault) begin
                    delayed <= 1'b1; // RL17
                end else if (obj != obj_q && obj != delayed && dly_s == 12'd0) begin
                    delayed <= obj; // RL11
                end else if (dly_exp && !dly_stop) begin
                    delayed <= obj; // RL12
                end
            end
        end

        // Telegram triggers
        always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
                fault_cnt          <= 2'd0;
                tx_valid[g]        <= 1'b0;
                threshold_level[g] <= 1'b0;
            end else if (clk_en) begin
                tx_valid[g]        <= 1'b0;
                threshold_level[g] <= delayed;
                if (fault && !fault_q) begin
                    fault_cnt <= FAULT_SENDS; // RL17
                end else if (fault_cnt != 2'd0) begin
                    fault_cnt   <= fault_cnt - 2'd1;
                    tx_valid[g] <= 1'b1; // RL17
                end else if (!silent) begin // RL4
                    if (delayed != delayed_q && cfg[g][CFG_SEND_CHG]) begin
                        tx_valid[g] <= 1'b1; // RL15 RL16
                    end else if (cyc_fire) begin
                        tx_valid[g] <= 1'b1; // RL18 RL19
                    end
                end
            end
        end
    end
endmodule : tol_top

//--- core/tol_pkg.sv
// Constants and helpers for the threshold object logic
//
// Contract
// [RL1] Twelve selectable activation modes choose set, reset and silent transitions.
// [RL2] Exceed modes: set above limit, clear below limit minus hysteresis.
// [RL3] Undershoot modes: set below limit, clear above limit plus hysteresis.
// [RL4] A silent state suppresses change and cyclic sends while it holds.
// [RL5] External 16-bit or 8-bit percent object may replace the limit.
// [RL6] Binary precipitation channel has no external limit and no teaching.
// [RL7] Teach object one captures the last measured value as limit; zero ignored.
// [RL8] Taught limit persists until new limit or download restores default.
// [RL9] Initialisation and every download reload the configured limit.
// [RL10] Rising internal state uses switch-on delay, falling uses switch-off delay.
// [RL11] No delay selected: delayed state follows internal state at once.
// [RL12] Delay timer loads; on expiry delayed state updates and sends.
// [RL13] Internal state reverting before expiry stops timer, no change telegram.
// [RL14] On and off delays per threshold from a fixed list up to an hour.
// [RL15] Send-on-change transmits each delayed state transition both ways.
// [RL16] Recurring active event retransmits even when reverse event is silent.
// [RL17] Supply monitoring fault forces precipitation state and sends it twice.
// [RL18] Cyclic repeat every factor times ten seconds; factor 0 to 120, zero off.
// [RL19] Change sends never alter the cyclic period timing.
// [RL20] Teaching push-button sends one only after a press over three seconds.
// [RL21] Cyclic sends halted by a silent state resume at the opposite state.
// [RL22] Two independent thresholds, each with own hysteresis and mode.
// [RL23] Comparison re-evaluated on every new measured value sample.
package tol_pkg;
    // ------
    // Timing and channel count
    // ------
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          SECOND_NS     = 1000000000;
    localparam int          TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
    localparam int          CYC_UNIT_S    = 10;
    localparam logic [6:0]  CYC_MAX       = 7'd120;
    localparam int          NUM_THR       = 2;
    // ------
    // Register map
    // ------
    localparam logic [5:0]  OFS_CTRL      = 6'h00;
    localparam logic [5:0]  OFS_MEAS      = 6'h04;
    localparam logic [3:0]  OFS_CFG       = 4'h0;
    localparam logic [3:0]  OFS_LIMIT     = 4'h4;
    localparam logic [3:0]  OFS_HYST      = 4'h8;
    localparam logic [3:0]  OFS_STATUS    = 4'hc;
    // ------
    // Field positions
    // ------
    localparam int          CTRL_RELOAD   = 0;
    localparam int          CFG_MODE_LO   = 0;
    localparam int          CFG_EXT_LO    = 4;
    localparam int          CFG_BINARY    = 6;
    localparam int          CFG_SEND_CHG  = 7;
    localparam int          CFG_ON_LO     = 8;
    localparam int          CFG_OFF_LO    = 12;
    localparam int          CFG_CYC_LO    = 16;
    localparam int          CFG_SUP_MON   = 24;
    // ------
    // Reset values and fixed constants
    // ------
    localparam logic [31:0] CFG_RESET     = 32'h0000_0080;
    localparam logic [15:0] LIMIT_RESET   = 16'h8000;
    localparam logic [15:0] HYST_RESET    = 16'h0100;
    localparam logic [15:0] PCT_SCALE     = 16'd655;
    localparam logic [7:0]  PCT_MAX       = 8'd100;
    localparam logic [1:0]  FAULT_SENDS   = 2'd2;
    // ------
    // Limit source selection
    // ------
    typedef enum logic [1:0] {
        TOL_EXT_NONE  = 2'b00,
        TOL_EXT_16    = 2'b01,
        TOL_EXT_8     = 2'b10,
        TOL_EXT_TEACH = 2'b11
    } tol_ext_t;

    // Mode decode: {undershoot, active level, active silent, inactive silent}
    function automatic logic [3:0] tol_mode(input logic [3:0] m);
        logic [3:0] r;
        r = 4'b0100;
        case (m)
            4'd0:    r = 4'b0100;
            4'd1:    r = 4'b0000;
            4'd2:    r = 4'b1100;
            4'd3:    r = 4'b1000;
            4'd4:    r = 4'b0101;
            4'd5:    r = 4'b0001;
            4'd6:    r = 4'b1101;
            4'd7:    r = 4'b1001;
            4'd8:    r = 4'b0110;
            4'd9:    r = 4'b0010;
            4'd10:   r = 4'b1110;
            4'd11:   r = 4'b1010;
            default: r = 4'b0100;
        endcase
        return r;
    endfunction : tol_mode

    // Delay list in seconds, index 0 means no delay
    function automatic logic [11:0] tol_delay_s(input logic [2:0] sel);
        logic [11:0] r;
        r = 12'h000;
        case (sel)
            3'd0:    r = 12'd0;
            3'd1:    r = 12'd1;
            3'd2:    r = 12'd5;
            3'd3:    r = 12'd10;
            3'd4:    r = 12'd30;
            3'd5:    r = 12'd60;
            3'd6:    r = 12'd600;
            3'd7:    r = 12'd3600;
            default: r = 12'd0;
        endcase
        return r;
    endfunction : tol_delay_s
endpackage : tol_pkg

//--- core/tol_delay.sv
// Delay timer
`timescale 1ns/1ps
module tol_delay
    import tol_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Timebase
    input  wire logic        tick,
    // Control
    input  wire logic        load,
    input  wire logic [11:0] secs,
    input  wire logic        stop,
    // Status
    output logic             busy,
    output logic             expire
);
    logic [11:0] remain;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remain <= 12'h000;
            busy   <= 1'b0;
            expire <= 1'b0;
        end else if (clk_en) begin
            expire <= 1'b0;
            if (stop) begin
                busy <= 1'b0;
            end else if (load) begin
                remain <= secs;
                busy   <= 1'b1;
            end else if (busy && tick) begin
                if (remain <= 12'd1) begin
                    busy   <= 1'b0;
                    expire <= 1'b1;
                end else begin
                    remain <= remain - 12'd1;
                end
            end
        end
    end
endmodule : tol_delay

//--- core/tol_cycle.sv
// Cyclic send timer
`timescale 1ns/1ps
module tol_cycle
    import tol_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Timebase and setting
    input  wire logic        tick,
    input  wire logic [6:0]  factor,
    // Event
    output logic             fire
);
    localparam logic [3:0] UNIT_LAST = 4'(CYC_UNIT_S - 1);
    logic [3:0] sec_cnt;
    logic [6:0] unit_cnt;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sec_cnt  <= 4'h0;
            unit_cnt <= 7'h00;
            fire     <= 1'b0;
        end else if (clk_en) begin
            fire <= 1'b0;
            if (factor == 7'd0 || factor > CYC_MAX) begin // RL18
                sec_cnt  <= 4'h0;
                unit_cnt <= 7'h00;
            end else if (tick) begin
                if (sec_cnt == UNIT_LAST) begin
                    sec_cnt <= 4'h0;
                    if (unit_cnt + 7'd1 >= factor) begin
                        unit_cnt <= 7'h00;
                        fire     <= 1'b1; // RL18
                    end else begin
                        unit_cnt <= unit_cnt + 7'd1;
                    end
                end else begin
                    sec_cnt <= sec_cnt + 4'd1;
                end
            end
        end
    end
endmodule : tol_cycle

//--- sim/tol_assertions.sv
// Port checker for the threshold object logic
`timescale 1ns/1ps
module tol_assertions (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // Bus
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Samples and telegrams
    input wire logic [15:0] meas_value,
    input wire logic        meas_valid,
    input wire logic [1:0]  tx_valid,
    input wire logic [1:0]  threshold_level
);
    logic [15:0] meas_hold;
    logic        rd_done;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    assign rd_done = avs_read && !avs_waitrequest;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            meas_hold <= 16'h0000;
        else if (meas_valid)
            meas_hold <= meas_value;
    end
    a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read wait wrong");
    a_write_wait: assert property ($rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("write wait wrong");
    a_idle_ready: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
        else $error("stray wait");
    a_reset_clear: assert property ($rose(reset_n) |-> threshold_level == 2'h0 && tx_valid == 2'h0)
        else $error("reset outputs");
    a_hole_zero: assert property (rd_done && (avs_address inside {6'h00, 6'h08, 6'h0c}
        || avs_address >= 6'h30) |-> avs_readdata == 32'h0)
        else $error("hole not zero");
    a_meas_read: assert property (rd_done && avs_address == 6'h04 |-> avs_readdata == {16'h0000, $past(meas_hold)})
        else $error("sample read");
    a_status_level: assert property (rd_done && avs_address == 6'h1c |-> avs_readdata[17] == threshold_level[0] && avs_readdata[31:20] == 12'h000)
        else $error("status level");
    a_tx_burst: assert property (tx_valid[0] ##1 tx_valid[0] |=> !tx_valid[0])
        else $error("long burst");
endmodule : tol_assertions
bind tol_top tol_assertions u_tol_chk (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas_value(meas_value),
    .meas_valid(meas_valid), .tx_valid(tx_valid), .threshold_level(threshold_level));

//--- sim/tol_partner.sv
// Far-side model: telegram receiver and teaching push-button
`timescale 1ns/1ps
module tol_partner #(
    parameter int HOLD = 40
) (
    // Clock
    input wire logic       mclk,
    // Telegrams from the block
    input wire logic [1:0] tx_valid,
    input wire logic [1:0] threshold_level,
    // Button held by the bench
    input wire logic       press,
    // Teach telegrams and receive log
    output logic [1:0]     teach_valid = 2'h0,
    output logic [1:0]     teach_value = 2'h0,
    output int             rx_count = 0,
    output logic           rx_last = 1'b0
);
    int held = 0;
    always @(posedge mclk) begin
        if (tx_valid[0]) begin
            rx_count <= rx_count + 1;
            rx_last <= threshold_level[0];
        end
        held <= press ? held + 1 : 0;
        teach_valid <= {1'b0, !press && held != 0};
        teach_value <= {1'b0, held > HOLD};
    end
endmodule : tol_partner

//--- sim/test_tol_top.sv
// Self-checking bench for the threshold object logic
`timescale 1ns/1ps
module test_tol_top;
    import tol_pkg::*;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [31:0] LIM = 32'h0000_ffff;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic        press = 1'b0, sup = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, rx_last;
    logic [15:0] meas_value = 16'h0;
    logic        meas_valid = 1'b0;
    logic [1:0]  ext16_valid = 2'h0;
    logic [31:0] ext16_value = 32'h0;
    logic [1:0]  teach_valid, teach_value, tx_valid, threshold_level;
    int          rx_count, n;
    int          failures = 0;
    int          samples_checked = 0;
    always #25 mclk = ~mclk;
    tol_top #(.TICK_LEN(10)) DUT (.mclk(mclk), .reset_n(reset_n), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .meas_value(meas_value), .meas_valid(meas_valid),
        .supply_ok(sup), .ext16_valid(ext16_valid), .ext16_value(ext16_value),
        .ext8_valid(2'h0), .ext8_value(16'h0), .teach_valid(teach_valid),
        .teach_value(teach_value), .tx_valid(tx_valid), .threshold_level(threshold_level));
    tol_partner u_far (.mclk(mclk), .tx_valid(tx_valid), .threshold_level(threshold_level),
        .press(press), .teach_valid(teach_valid), .teach_value(teach_value),
        .rx_count(rx_count), .rx_last(rx_last));
    // ------
    // Shared tasks
    // ------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        @(posedge mclk iff avs_waitrequest === 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("register", rd & m, e);
    endtask : rc
    task automatic smp(input logic [15:0] v, input int w);
        meas_value <= v;
        meas_valid <= 1'b1;
        @(posedge mclk);
        meas_valid <= 1'b0;
        repeat (w) @(posedge mclk);
    endtask : smp
    task automatic lvl(input logic l, input int c);
        chk("level", {31'h0, threshold_level[0]}, {31'h0, l});
        chk("telegrams", rx_count, c);
    endtask : lvl
    task automatic hold(input int c);
        press <= 1'b1;
        repeat (c) @(posedge mclk);
        press <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : hold
    task automatic ext(input logic [15:0] v);
        ext16_value <= {16'h0, v};
        ext16_valid <= 2'h1;
        @(posedge mclk);
        ext16_valid <= 2'h0;
        repeat (3) @(posedge mclk);
    endtask : ext
    task automatic wt;
        int c;
        c = rx_count;
        n = 0;
        while (rx_count == c && n < 300) begin
            @(posedge mclk);
            n++;
        end
    endtask : wt
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        rc(6'h10, ALL, 32'h0000_0080);
        rc(6'h14, ALL, 32'h0000_8000);
        rc(6'h18, ALL, 32'h0000_0100);
        bus(1'b1, 6'h08, ALL);
        rc(6'h08, ALL, 32'h0);
        $display("regs done");
    endtask : t_regs
    task automatic t_modes;
        smp(16'h9000, 4);
        lvl(1'b1, 1);
        smp(16'h7f80, 4);
        lvl(1'b1, 1);
        smp(16'h7e00, 4);
        lvl(1'b0, 2);
        bus(1'b1, 6'h10, 32'h0000_0084);
        smp(16'h9000, 4);
        smp(16'h7e00, 4);
        lvl(1'b0, 3);
        smp(16'h9000, 4);
        lvl(1'b1, 4);
        $display("modes done");
    endtask : t_modes
    task automatic t_delay;
        bus(1'b1, 6'h10, 32'h0000_0080);
        smp(16'h7e00, 4);
        bus(1'b1, 6'h10, 32'h0000_0380);
        smp(16'h9000, 50);
        lvl(1'b0, 5);
        smp(16'h7e00, 100);
        lvl(1'b0, 5);
        smp(16'h9000, 130);
        lvl(1'b1, 6);
        $display("delay done");
    endtask : t_delay
    task automatic t_limit;
        bus(1'b1, 6'h10, 32'h0000_00b0);
        smp(16'h1234, 4);
        hold(5);
        rc(6'h1c, LIM, 32'h0000_8000);
        hold(45);
        smp(16'h5555, 4);
        rc(6'h1c, LIM, 32'h0000_1234);
        bus(1'b1, 6'h00, 32'h0000_0001);
        rc(6'h1c, LIM, 32'h0000_8000);
        bus(1'b1, 6'h10, 32'h0000_0090);
        ext(16'h4321);
        rc(6'h1c, LIM, 32'h0000_4321);
        bus(1'b1, 6'h10, 32'h0000_00d0);
        ext(16'h1111);
        rc(6'h1c, LIM, 32'h0000_4321);
        $display("limit done");
    endtask : t_limit
    task automatic t_cyc;
        bus(1'b1, 6'h10, 32'h0001_0080);
        wt();
        wt();
        chk("period", n, 100);
        bus(1'b1, 6'h10, 32'h0000_0080);
        wt();
        chk("no repeat", n, 300);
        bus(1'b1, 6'h10, 32'h0100_00c0);
        n = rx_count;
        sup <= 1'b0;
        repeat (9) @(posedge mclk);
        lvl(1'b1, n + 2);
        $display("cyclic done");
    endtask : t_cyc
    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_regs();
        t_modes();
        t_delay();
        t_limit();
        t_cyc();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        stop_test();
    end
endmodule : test_tol_top
